/* hdl/sld_led_top.sv */
// Top of the link and host status LED driver with its APB register slave.
//
// How it works
// - Every optical port has its own two-colour lamp driven from that link's own status.
// - Until the system is initialised each link lamp is steady orange.
// - An initialised link with no camera pulses red at the slow rate.
// - While camera detection runs the link lamp flashes orange at the fast rate.
// - A connected camera with no data moving gives steady green.
// - A connected camera waiting for a trigger gives slow orange pulses.
// - A connected camera moving image data gives fast green flashes.
// - While test packets are sent the lamp alternates slowly between green and orange.
// - Status lamp 0 blinks while the host reference clock is seen and goes dark otherwise.
// - Status lamp 1 is lit only while the host link is in its active L0 state.
// - Status lamp 2 is lit at the third-generation rate and dark at the first two.
// - Status lamp 3 is lit when all eight lanes are up and dark at one or four.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
module sld_led_top
  import sld_pkg::*;
#(
  parameter int unsigned SLOW_PERIOD = SLOW_PERIOD_CYC,
  parameter int unsigned FAST_PERIOD = FAST_PERIOD_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sys_ready,
  input wire logic [LINK_COUNT-1:0] link_test_tx,
  input wire logic [LINK_COUNT-1:0] link_detecting,
  input wire logic [LINK_COUNT-1:0] link_cam_present,
  input wire logic [LINK_COUNT-1:0] link_xfer_active,
  input wire logic [LINK_COUNT-1:0] link_trig_wait,
  input wire logic pcie_clk_beat,
  input wire logic pcie_l0,
  input wire logic [1:0] pcie_rate,
  input wire logic [3:0] pcie_lanes,
  output logic [LINK_COUNT-1:0] link_led_red,
  output logic [LINK_COUNT-1:0] link_led_green,
  output logic [3:0] status_led
);

  // Control register.
  logic [CTRL_W-1:0] ctrl;
  logic sys_init;
  logic lamp_test;
  logic dark;

  // Sampled inputs, so every lamp decision in a cycle sees one snapshot.
  logic in_ready;
  logic [LINK_COUNT-1:0] in_test;
  logic [LINK_COUNT-1:0] in_detect;
  logic [LINK_COUNT-1:0] in_present;
  logic [LINK_COUNT-1:0] in_xfer;
  logic [LINK_COUNT-1:0] in_trig;
  logic in_beat;
  logic beat_prev;
  logic in_l0;
  logic [1:0] in_rate;
  logic [3:0] in_lanes;

  // Host clock watchdog and host link decodes.
  logic [ALIVE_W-1:0] alive_cnt;
  logic alive;
  logic gen3;
  logic full_width;

  // Blink timebases.
  logic slow_sq;
  logic slow_pulse;
  logic fast_sq;
  logic fast_pulse_unused;

  // Per-link and host state for readback.
  sld_link_state_t link_state [LINK_COUNT];
  logic [31:0] link_word;
  logic [31:0] pcie_word;

  // Bus decode.
  logic access;
  logic addr_ok;
  logic [31:0] rd_value;

  assign sys_init = in_ready & ctrl[CTRL_INIT_BIT];
  assign lamp_test = ctrl[CTRL_LAMP_BIT];
  assign dark = ctrl[CTRL_DARK_BIT];
  assign alive = alive_cnt != '0;
  assign gen3 = in_rate == PCIE_RATE_GEN3;
  assign full_width = in_lanes == PCIE_LANES_FULL;
  assign access = psel & penable;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      in_ready <= 1'b0;
      in_test <= '0;
      in_detect <= '0;
      in_present <= '0;
      in_xfer <= '0;
      in_trig <= '0;
    end else begin
      in_ready <= sys_ready;
      in_test <= link_test_tx;
      in_detect <= link_detecting;
      in_present <= link_cam_present;
      in_xfer <= link_xfer_active;
      in_trig <= link_trig_wait;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      in_beat <= 1'b0;
      beat_prev <= 1'b0;
      in_l0 <= 1'b0;
      in_rate <= 2'h0;
      in_lanes <= 4'h0;
    end else begin
      in_beat <= pcie_clk_beat;
      beat_prev <= in_beat;
      in_l0 <= pcie_l0;
      in_rate <= pcie_rate;
      in_lanes <= pcie_lanes;
    end
  end

  // The beat toggles from the host clock side; a missing edge for the
  // timeout means the host clock has stopped.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      alive_cnt <= '0;
    end else if (in_beat != beat_prev) begin
      alive_cnt <= ALIVE_W'(ALIVE_TIMEOUT_CYC);
    end else if (alive) begin
      alive_cnt <= alive_cnt - 1'b1;
    end
  end

  sld_blink_gen #(
    .PERIOD(SLOW_PERIOD)
  ) u_slow (
    .core_clk(core_clk),
    .srst(srst),
    .sq(slow_sq),
    .pulse(slow_pulse)
  );

  sld_blink_gen #(
    .PERIOD(FAST_PERIOD)
  ) u_fast (
    .core_clk(core_clk),
    .srst(srst),
    .sq(fast_sq),
    .pulse(fast_pulse_unused)
  );

  for (genvar i = 0; i < LINK_COUNT; i++) begin : g_link
    sld_link_led u_led (
      .core_clk(core_clk),
      .srst(srst),
      .sys_init(sys_init),
      .test_tx(in_test[i]),
      .detecting(in_detect[i]),
      .cam_present(in_present[i]),
      .xfer_active(in_xfer[i]),
      .trig_wait(in_trig[i]),
      .slow_sq(slow_sq),
      .slow_pulse(slow_pulse),
      .fast_sq(fast_sq),
      .lamp_test(lamp_test),
      .dark(dark),
      .state(link_state[i]),
      .led_red(link_led_red[i]),
      .led_green(link_led_green[i])
    );
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      status_led <= 4'h0;
    end else if (lamp_test) begin
      status_led <= 4'hF;
    end else if (dark) begin
      status_led <= 4'h0;
    end else begin
      status_led[0] <= alive & slow_sq;
      status_led[1] <= in_l0;
      status_led[2] <= gen3;
      status_led[3] <= full_width;
    end
  end

  always_comb begin
    link_word = '0;
    for (int i = 0; i < LINK_COUNT; i++) begin
      link_word[i*LINK_FIELD_W +: LINK_FIELD_W] = link_state[i];
    end
    link_word[LINK_PRESENT_LSB +: LINK_COUNT] = in_present;
  end

  always_comb begin
    pcie_word = '0;
    pcie_word[PCIE_ALIVE_BIT] = alive;
    pcie_word[PCIE_L0_BIT] = in_l0;
    pcie_word[PCIE_GEN3_BIT] = gen3;
    pcie_word[PCIE_X8_BIT] = full_width;
    pcie_word[PCIE_RATE_LSB +: 2] = in_rate;
    pcie_word[PCIE_LANES_LSB +: 4] = in_lanes;
  end

  // Status registers are read-only, so a write to them is an error.
  always_comb begin
    addr_ok = 1'b0;
    rd_value = '0;
    case (paddr)
      REG_CTRL: begin
        addr_ok = 1'b1;
        rd_value[CTRL_W-1:0] = ctrl;
      end
      REG_LINK_STATE: begin
        addr_ok = !pwrite;
        rd_value = link_word;
      end
      REG_PCIE_STATE: begin
        addr_ok = !pwrite;
        rd_value = pcie_word;
      end
      default: begin
        addr_ok = 1'b0;
        rd_value = '0;
      end
    endcase
  end

  // One wait state keeps prdata, pready and pslverr straight from flops.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (access && !pready) begin
      pready <= 1'b1;
      pslverr <= !addr_ok;
      prdata <= (addr_ok && !pwrite) ? rd_value : 32'h0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl <= CTRL_RESET;
    end else if (access && pready && pwrite && paddr == REG_CTRL && pstrb[0]) begin
      ctrl <= pwdata[CTRL_W-1:0];
    end
  end

endmodule

/* common/sld_pkg.sv */
// Shared constants and types of the link and host status LED driver.
package sld_pkg;

  localparam int unsigned LINK_COUNT = 4;

  // Core clock rate and blink timing.
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SLOW_PERIOD_MS = 1000;
  localparam int unsigned FAST_PERIOD_MS = 200;
  localparam int unsigned ALIVE_TIMEOUT_US = 10;
  localparam int unsigned SLOW_PERIOD_CYC = SLOW_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned FAST_PERIOD_CYC = FAST_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned ALIVE_TIMEOUT_CYC = ALIVE_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DIV_W = 24;
  localparam int unsigned ALIVE_W = 8;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LINK_STATE = 8'h04;
  localparam logic [7:0] REG_PCIE_STATE = 8'h08;

  // Control register fields and reset value.
  localparam int unsigned CTRL_W = 3;
  localparam int unsigned CTRL_INIT_BIT = 0;
  localparam int unsigned CTRL_LAMP_BIT = 1;
  localparam int unsigned CTRL_DARK_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Link state register: one field per link.
  localparam int unsigned LINK_FIELD_W = 3;
  localparam int unsigned LINK_PRESENT_LSB = 16;

  // Host status register fields.
  localparam int unsigned PCIE_ALIVE_BIT = 0;
  localparam int unsigned PCIE_L0_BIT = 1;
  localparam int unsigned PCIE_GEN3_BIT = 2;
  localparam int unsigned PCIE_X8_BIT = 3;
  localparam int unsigned PCIE_RATE_LSB = 4;
  localparam int unsigned PCIE_LANES_LSB = 8;

  // Host link encodings.
  localparam logic [1:0] PCIE_RATE_GEN3 = 2'h2;
  localparam logic [3:0] PCIE_LANES_FULL = 4'h8;

  // Indicator state in order of precedence, highest first.
  typedef enum logic [2:0] {
    SLD_UNINIT,
    SLD_TEST,
    SLD_DETECT,
    SLD_NOCAM,
    SLD_XFER,
    SLD_TRIG,
    SLD_IDLE
  } sld_link_state_t;

endpackage

/* hdl/sld_blink_gen.sv */
// Free-running blink timebase with a half-duty square and a short pulse.
`timescale 1ns/1ps
module sld_blink_gen
  import sld_pkg::*;
#(
  parameter int unsigned PERIOD = 16
) (
  input wire logic core_clk,
  input wire logic srst,
  output logic sq,
  output logic pulse
);

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;

  always_comb begin
    if (cnt == DIV_W'(PERIOD - 1)) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // The pulse is a quarter-period on-time so it reads as a pulse, not a flash.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sq <= 1'b0;
      pulse <= 1'b0;
    end else begin
      sq <= next_cnt < DIV_W'(PERIOD / 2);
      pulse <= next_cnt < DIV_W'(PERIOD / 4);
    end
  end

endmodule

/* hdl/sld_link_led.sv */
// One bi-colour link indicator: state selection and colour drive.
`timescale 1ns/1ps
module sld_link_led
  import sld_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sys_init,
  input wire logic test_tx,
  input wire logic detecting,
  input wire logic cam_present,
  input wire logic xfer_active,
  input wire logic trig_wait,
  input wire logic slow_sq,
  input wire logic slow_pulse,
  input wire logic fast_sq,
  input wire logic lamp_test,
  input wire logic dark,
  output sld_link_state_t state,
  output logic led_red,
  output logic led_green
);

  sld_link_state_t next_state;
  logic next_red;
  logic next_green;

  always_comb begin
    if (!sys_init) begin
      next_state = SLD_UNINIT;
    end else if (test_tx) begin
      next_state = SLD_TEST;
    end else if (detecting) begin
      next_state = SLD_DETECT;
    end else if (!cam_present) begin
      next_state = SLD_NOCAM;
    end else if (xfer_active) begin
      next_state = SLD_XFER;
    end else if (trig_wait) begin
      next_state = SLD_TRIG;
    end else begin
      next_state = SLD_IDLE;
    end
  end

  // Orange is red and green lit together.
  always_comb begin
    case (next_state)
      SLD_UNINIT: begin
        next_red = 1'b1;
        next_green = 1'b1;
      end
      SLD_TEST: begin
        next_red = slow_sq;
        next_green = 1'b1;
      end
      SLD_DETECT: begin
        next_red = fast_sq;
        next_green = fast_sq;
      end
      SLD_NOCAM: begin
        next_red = slow_pulse;
        next_green = 1'b0;
      end
      SLD_XFER: begin
        next_red = 1'b0;
        next_green = fast_sq;
      end
      SLD_TRIG: begin
        next_red = slow_pulse;
        next_green = slow_pulse;
      end
      SLD_IDLE: begin
        next_red = 1'b0;
        next_green = 1'b1;
      end
      default: begin
        next_red = 1'b0;
        next_green = 1'b0;
      end
    endcase
  end

  // Lamp test overrides dark so a board check always sees every lamp.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= SLD_UNINIT;
      led_red <= 1'b1;
      led_green <= 1'b1;
    end else begin
      state <= next_state;
      led_red <= lamp_test | (!dark & next_red);
      led_green <= lamp_test | (!dark & next_green);
    end
  end

endmodule

/* sim/sld_lamp_model.sv */
// Behavioural model of the bi-colour link lamps: red and green together glow orange.
`timescale 1ns/1ps
module sld_lamp_model (
  input wire logic [3:0] led_red,
  input wire logic [3:0] led_green,
  output logic [3:0] orange
);
  // Each link has its own lamp; the two dies of one lamp mix to orange.
  assign orange = led_red & led_green;
endmodule

/* sim/sld_led_props.sv */
// Concurrent checks on the ports of the LED driver top.
`timescale 1ns/1ps
module sld_led_props
  import sld_pkg::*;
#(
  parameter int unsigned SLOW_PERIOD = 16,
  parameter int unsigned FAST_PERIOD = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sys_ready,
  input wire logic [LINK_COUNT-1:0] link_test_tx,
  input wire logic [LINK_COUNT-1:0] link_detecting,
  input wire logic [LINK_COUNT-1:0] link_cam_present,
  input wire logic [LINK_COUNT-1:0] link_xfer_active,
  input wire logic [LINK_COUNT-1:0] link_trig_wait,
  input wire logic pcie_clk_beat,
  input wire logic pcie_l0,
  input wire logic [1:0] pcie_rate,
  input wire logic [3:0] pcie_lanes,
  input wire logic [LINK_COUNT-1:0] link_led_red,
  input wire logic [LINK_COUNT-1:0] link_led_green,
  input wire logic [3:0] status_led
);
  logic [2:0] ctrl_q;
  logic [1:0] age;
  logic beat_q;
  logic [7:0] idle;
  logic [8:0] h1, h2, h3, hi, lo;
  logic norm, ini, wr_ctrl;
  assign wr_ctrl = psel && penable && pready && pwrite && paddr == REG_CTRL && pstrb[0];
  assign hi = h1 & h2 & h3;
  assign lo = ~(h1 | h2 | h3);
  assign norm = age == 2'h3 && ctrl_q[2:1] == 2'h0;
  assign ini = norm && ctrl_q[0] && hi[5];
  // Checks pause for three cycles after a control write, while its effect moves through.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q <= CTRL_RESET;
      age <= 2'h0;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[2:0];
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    h1 <= {pcie_l0, pcie_rate == PCIE_RATE_GEN3, pcie_lanes == PCIE_LANES_FULL, sys_ready,
           link_test_tx[0], link_detecting[0], link_cam_present[0], link_xfer_active[0],
           link_trig_wait[0]};
    h2 <= h1;
    h3 <= h2;
  end
  always_ff @(posedge core_clk) begin
    beat_q <= pcie_clk_beat;
    if (srst || beat_q != pcie_clk_beat) begin
      idle <= 8'h00;
    end else if (idle != 8'hFF) begin
      idle <= idle + 8'h01;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  chk_ready_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready not one wait state");
  chk_uninit_orange: assert property (norm && (!ctrl_q[0] || lo[5]) |-> &link_led_red && &link_led_green)
    else $error("link lamps not orange");
  chk_test_green: assert property (norm && hi[4] |-> link_led_green[0])
    else $error("test lamp green missing");
  chk_detect_pair: assert property (ini && lo[4] && hi[3] |-> link_led_red[0] == link_led_green[0])
    else $error("detect lamp not orange");
  chk_nocam_red: assert property (ini && &lo[4:2] |-> !link_led_green[0])
    else $error("no camera lamp shows green");
  chk_xfer_green: assert property (ini && &lo[4:3] && &hi[2:1] |-> !link_led_red[0])
    else $error("transfer lamp shows red");
  chk_alive_dark: assert property (norm && idle > ALIVE_TIMEOUT_CYC + 8 |-> !status_led[0])
    else $error("alive lamp lit without beat");
  chk_l0_lamp: assert property (norm && (hi[8] || lo[8]) |-> status_led[1] == hi[8])
    else $error("L0 lamp wrong");
  chk_gen3_lamp: assert property (norm && (hi[7] || lo[7]) |-> status_led[2] == hi[7])
    else $error("rate lamp wrong");
  chk_x8_lamp: assert property (norm && (hi[6] || lo[6]) |-> status_led[3] == hi[6])
    else $error("lane lamp wrong");
endmodule
bind sld_led_top sld_led_props #(.SLOW_PERIOD(SLOW_PERIOD), .FAST_PERIOD(FAST_PERIOD)) u_props (
  .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sys_ready(sys_ready), .link_test_tx(link_test_tx),
  .link_detecting(link_detecting), .link_cam_present(link_cam_present),
  .link_xfer_active(link_xfer_active), .link_trig_wait(link_trig_wait),
  .pcie_clk_beat(pcie_clk_beat), .pcie_l0(pcie_l0), .pcie_rate(pcie_rate),
  .pcie_lanes(pcie_lanes), .link_led_red(link_led_red), .link_led_green(link_led_green),
  .status_led(status_led)
);

/* sim/tb_top.sv */
// Self-checking testbench of the LED driver top.
`timescale 1ns/1ps
module tb_top;
  import sld_pkg::*;
  logic core_clk, srst, psel, penable, pwrite, pready, pslverr, sys_ready, er;
  logic pcie_clk_beat, pcie_l0, beat_on;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, pcie_lanes, link_led_red, link_led_green, status_led, orange;
  logic [3:0] link_test_tx, link_detecting, link_cam_present, link_xfer_active, link_trig_wait;
  logic [1:0] pcie_rate;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rc[4], gc[4], oc[4], sc[4];
  sld_led_top #(.SLOW_PERIOD(16), .FAST_PERIOD(8)) dut (
    .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sys_ready(sys_ready), .link_test_tx(link_test_tx),
    .link_detecting(link_detecting), .link_cam_present(link_cam_present),
    .link_xfer_active(link_xfer_active), .link_trig_wait(link_trig_wait),
    .pcie_clk_beat(pcie_clk_beat), .pcie_l0(pcie_l0), .pcie_rate(pcie_rate),
    .pcie_lanes(pcie_lanes), .link_led_red(link_led_red), .link_led_green(link_led_green),
    .status_led(status_led)
  );
  sld_lamp_model lamps (.led_red(link_led_red), .led_green(link_led_green), .orange(orange));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // The host clock beat toggles every fourth cycle, well inside the alive timeout.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (beat_on && cyc % 4 == 0) pcie_clk_beat <= ~pcie_clk_beat;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task cmp_w(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmp_n(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, s};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) n_mismatch++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task set_links(input logic [3:0] t, d, c, x, w);
    @(posedge core_clk);
    {link_test_tx, link_detecting, link_cam_present, link_xfer_active, link_trig_wait} <=
      {t, d, c, x, w};
  endtask
  // Sixteen cycles span one slow and two fast periods, so counts do not depend on phase.
  task meas;
    repeat (8) @(posedge core_clk);
    rc = '{0, 0, 0, 0};
    gc = '{0, 0, 0, 0};
    oc = '{0, 0, 0, 0};
    sc = '{0, 0, 0, 0};
    repeat (16) begin
      @(posedge core_clk);
      for (int i = 0; i < 4; i++) begin
        rc[i] += int'(link_led_red[i] === 1'b1);
        gc[i] += int'(link_led_green[i] === 1'b1);
        oc[i] += int'(orange[i] === 1'b1);
        sc[i] += int'(status_led[i] === 1'b1);
      end
    end
  endtask
  task chk_l(input int i, input int r, input int g, input int o);
    cmp_n(rc[i], r);
    cmp_n(gc[i], g);
    cmp_n(oc[i], o);
  endtask
  task t_uninit;
    apb(1'b1, REG_CTRL, 32'h1, 4'h0);
    apb(1'b0, REG_CTRL, 32'h0, 4'hF);
    cmp_w(rd, 32'h0);
    apb(1'b0, 8'hFC, 32'h0, 4'hF);
    cmp_w({31'h0, er}, 32'h1);
    apb(1'b1, REG_LINK_STATE, 32'h0, 4'hF);
    cmp_w({31'h0, er}, 32'h1);
    sys_ready <= 1'b1;
    meas;
    for (int i = 0; i < 4; i++) chk_l(i, 16, 16, 16);
    apb(1'b1, REG_CTRL, 32'h1, 4'h1);
    sys_ready <= 1'b0;
    meas;
    for (int i = 0; i < 4; i++) chk_l(i, 16, 16, 16);
  endtask
  task t_links;
    sys_ready <= 1'b1;
    set_links(4'h1, 4'h3, 4'hD, 4'h4, 4'hC);
    meas;
    chk_l(0, 8, 16, 8);
    chk_l(1, 8, 8, 8);
    chk_l(2, 0, 8, 0);
    chk_l(3, 4, 4, 4);
    apb(1'b0, REG_LINK_STATE, 32'h0, 4'hF);
    cmp_w(rd, 32'h000D_0B11);
    set_links(4'h0, 4'h0, 4'hF, 4'h0, 4'h0);
    meas;
    for (int i = 0; i < 4; i++) chk_l(i, 0, 16, 0);
    apb(1'b0, REG_LINK_STATE, 32'h0, 4'hF);
    cmp_w(rd, 32'h000F_0DB6);
    set_links(4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
    meas;
    for (int i = 0; i < 4; i++) chk_l(i, 4, 0, 0);
  endtask
  task t_host;
    {beat_on, pcie_l0, pcie_rate, pcie_lanes} <= {1'b1, 1'b1, PCIE_RATE_GEN3, PCIE_LANES_FULL};
    meas;
    cmp_n(sc[0], 8);
    for (int i = 1; i < 4; i++) cmp_n(sc[i], 16);
    apb(1'b0, REG_PCIE_STATE, 32'h0, 4'hF);
    cmp_w(rd, 32'h0000_082F);
    {pcie_l0, pcie_rate, pcie_lanes} <= {1'b0, 2'h1, 4'h4};
    meas;
    for (int i = 1; i < 4; i++) cmp_n(sc[i], 0);
    beat_on <= 1'b0;
    repeat (120) @(posedge core_clk);
    meas;
    cmp_n(sc[0], 0);
    apb(1'b0, REG_PCIE_STATE, 32'h0, 4'hF);
    cmp_w(rd, 32'h0000_0410);
  endtask
  task over_one(input logic [2:0] c, input int e);
    apb(1'b1, REG_CTRL, {29'h0, c}, 4'hF);
    meas;
    for (int i = 0; i < 4; i++) begin
      chk_l(i, e, e, e);
      cmp_n(sc[i], e);
    end
  endtask
  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, sys_ready, pcie_clk_beat, pcie_l0, beat_on} = '0;
    {paddr, pwdata, pstrb, pcie_rate, pcie_lanes} = '0;
    {link_test_tx, link_detecting, link_cam_present, link_xfer_active, link_trig_wait} = '0;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    t_uninit;
    t_links;
    t_host;
    over_one(3'h3, 16);
    over_one(3'h5, 0);
    over_one(3'h7, 16);
    tally_and_finish;
  end
endmodule
